// *** hdl/tw_pkg.sv ***
// Purpose: shared constants and types for the three-wire configuration port
// Assumes: 20 MHz system clock, 7-bit addresses, 16-bit registers
// Notes: frame positions count rising serial clock edges taken while select is low
package tw_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int FRAME_W = 1 + 1 + ADDR_W + DATA_W;
	localparam logic START_BIT = 1'b1;
	localparam logic OP_WRITE = 1'b0;
	localparam logic OP_READ = 1'b1;

	// device side: index of the bit taken at each rising edge with select low
	localparam logic [4:0] IDX_OP = 5'h01;
	localparam logic [4:0] IDX_ADDR_FIRST = 5'h02;
	localparam logic [4:0] IDX_ADDR_LAST = 5'h08;
	localparam logic [4:0] IDX_DATA_FIRST = 5'h09;
	localparam logic [4:0] IDX_DATA_LAST = 5'h18;
	localparam logic [4:0] IDX_WR_DONE = 5'h19;
	localparam logic [4:0] IDX_RD_LAUNCH = 5'h0b;
	localparam logic [4:0] IDX_RD_RELEASE = 5'h1b;
	localparam logic [4:0] IDX_MAX = 5'h1f;

	// host side: number of the rising edge since the serial clock started
	localparam logic [4:0] E_SEL_LOW = 5'h01;
	localparam logic [4:0] E_LAST_WR = 5'h1a;
	localparam logic [4:0] E_HOST_REL_RD = 5'h0a;
	localparam logic [4:0] E_CAP_FIRST = 5'h0d;
	localparam logic [4:0] E_CAP_LAST = 5'h1c;
	localparam logic [4:0] E_LAST_RD = 5'h1d;
	localparam logic [4:0] E_RST_LOW = 5'h04;
	localparam logic [4:0] E_RST_PERIODS = 5'h07;

	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_KHZ = 20000;
	localparam int SCLK_MAX_KHZ = 19200;
	localparam int HALF_DIV_MIN = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
	localparam int HALF_DIV_DEF = 4;
	localparam int RST_MIN_NS = 100;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CT_TIME_US = 50;
	localparam int KV_TIME_US = 100;
	localparam int XO_SETTLE_US = 500;
	localparam int CT_CYC = CT_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int KV_CYC = KV_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int XO_SETTLE_CYC = XO_SETTLE_US * 1000 / CLK_PERIOD_NS;
	localparam int TMR_W = 12;

	// register map
	localparam logic [ADDR_W-1:0] REG_CFG1 = 7'h00;
	localparam logic [ADDR_W-1:0] REG_CFG3 = 7'h02;
	localparam logic [ADDR_W-1:0] REG_BANK1 = 7'h08;
	localparam logic [ADDR_W-1:0] REG_BANK2 = 7'h10;
	localparam int BOTH_MIXERS_SELECT_BIT = 1;
	localparam int CRYSTAL_KEEP_ALIVE_BIT = 0;
	localparam int CT_EN_BIT = 12;
	localparam int KV_EN_BIT = 11;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

	typedef enum logic [1:0] {TH_IDLE = 2'b00, TH_RUN = 2'b01, TH_RST = 2'b11} tw_host_state_type;
	typedef enum logic [1:0] {TC_IDLE = 2'b00, TC_CT = 2'b01, TC_KV = 2'b11} tw_cal_state_type;
endpackage

// *** hdl/tw_if.sv ***
// Purpose: the pins between controller and device
// Assumes: the data line has a weak pull-up
// Notes: the shared line level is resolved here from both enables
`timescale 1ns/1ns
interface tw_if;
	logic sclk;
	logic serial_select_n;
	logic host_io_o;
	logic host_io_oe;
	logic dev_io_o;
	logic dev_io_oe;
	logic serial_io_line;
	logic chip_power_on;
	logic hard_reset_n;
	logic mode;

	// pull-up wins when neither side drives
	assign serial_io_line = host_io_oe ? host_io_o : (dev_io_oe ? dev_io_o : 1'b1);

	modport host (output sclk, output serial_select_n, output host_io_o, output host_io_oe,
		output chip_power_on, output hard_reset_n, output mode, input serial_io_line);
	modport dev (input sclk, input serial_select_n, input serial_io_line, input chip_power_on,
		input hard_reset_n, input mode, output dev_io_o, output dev_io_oe);
endinterface

// *** hdl/tw_sync.sv ***
// Purpose: two-flop level synchroniser, one per bit
// Assumes: each bit is a level that changes slowly against clk
// Notes: no reset, the chain flushes within two edges
`timescale 1ns/1ns
module tw_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds the second only
	always_ff @(posedge clk)
	begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule // tw_sync

// *** hdl/tw_dev.sv ***
// Purpose: device end of the three-wire port with its hardware control pins
// Assumes: serial logic runs on the link clock only, control logic on clk
// Notes: register contents beyond the few control bits are plain storage
`timescale 1ns/1ns
module tw_dev (
	input wire logic clk,
	input wire logic resetn,
	tw_if.dev bus,
	output logic digital_on,
	output logic analog_on,
	output logic xo_bias_on,
	output logic bank2_active,
	output logic mixer1_on,
	output logic mixer2_on,
	output logic ct_busy,
	output logic kv_busy
);
	import tw_pkg::*;

	logic srst_n;
	logic [4:0] cnt_q;
	logic op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wsh_q;
	logic [DATA_W-1:0] rsh_q;
	logic out_q;
	logic oe_q;
	logic [DATA_W-1:0] regs_q [0:(1<<ADDR_W)-1];
	logic [8:0] cfg_raw;
	logic [8:0] cfg_s;
	logic mode_s;
	logic pwr_s;
	logic hrst_s;
	logic keep_s;
	logic duplex_s;
	logic ct1_s;
	logic kv1_s;
	logic ct2_s;
	logic kv2_s;
	logic ct_en;
	logic kv_en;
	logic crst_n;
	logic pwr_d_q;
	logic pwr_rise;
	tw_cal_state_type cal_q;
	logic [TMR_W-1:0] tmr_q;

	// serial side reset: power-on and hard reset pin, taken on the link clock
	tw_sync #(.W(1)) u_srst (
		.clk(bus.sclk),
		.d(resetn & bus.hard_reset_n),
		.q(srst_n)
	);

	assign bus.dev_io_o = out_q;
	assign bus.dev_io_oe = oe_q;

	// frame shifter; select and data change on falling edges so they are settled at rising ones
	always_ff @(posedge bus.sclk)
	begin
		if (!srst_n)
		begin
			cnt_q <= 5'h00;
			op_q <= OP_WRITE;
			addr_q <= '0;
			wsh_q <= '0;
			rsh_q <= '0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else if (bus.serial_select_n)
		begin
			cnt_q <= 5'h00;
			oe_q <= 1'b0;
		end
		else
		begin
			// index 0 is the initialising start bit and carries nothing
			if (cnt_q != IDX_MAX)
				cnt_q <= cnt_q + 5'h01;
			if (cnt_q == IDX_OP)
				op_q <= bus.serial_io_line;
			if (cnt_q >= IDX_ADDR_FIRST && cnt_q <= IDX_ADDR_LAST)
				addr_q <= {addr_q[ADDR_W-2:0], bus.serial_io_line};
			if (op_q == OP_WRITE && cnt_q >= IDX_DATA_FIRST && cnt_q <= IDX_DATA_LAST)
				wsh_q <= {wsh_q[DATA_W-2:0], bus.serial_io_line};
			if (op_q == OP_READ && cnt_q == IDX_RD_LAUNCH)
			begin
				oe_q <= 1'b1;
				out_q <= regs_q[addr_q][DATA_W-1];
				rsh_q <= {regs_q[addr_q][DATA_W-2:0], 1'b0};
			end
			else if (op_q == OP_READ && cnt_q > IDX_RD_LAUNCH && cnt_q < IDX_RD_RELEASE)
			begin
				out_q <= rsh_q[DATA_W-1];
				rsh_q <= {rsh_q[DATA_W-2:0], 1'b0};
			end
			else if (cnt_q == IDX_RD_RELEASE)
				oe_q <= 1'b0;
		end
	end

	// register file; a frame cut short never reaches the full count, so it is dropped
	always_ff @(posedge bus.sclk)
	begin
		if (!srst_n)
		begin
			for (int i = 0; i < (1 << ADDR_W); i++)
				regs_q[i] <= REG_RESET;
		end
		else if (bus.serial_select_n && cnt_q == IDX_WR_DONE && op_q == OP_WRITE)
			regs_q[addr_q] <= wsh_q;
	end

	// control bits and pins into clk; each bit is a quasi-static level, so per-bit sync is enough
	assign cfg_raw = {bus.mode, bus.chip_power_on, bus.hard_reset_n,
		regs_q[REG_CFG3][CRYSTAL_KEEP_ALIVE_BIT], regs_q[REG_CFG1][BOTH_MIXERS_SELECT_BIT],
		regs_q[REG_BANK1][CT_EN_BIT], regs_q[REG_BANK1][KV_EN_BIT],
		regs_q[REG_BANK2][CT_EN_BIT], regs_q[REG_BANK2][KV_EN_BIT]};

	tw_sync #(.W(9)) u_cfg (
		.clk(clk),
		.d(cfg_raw),
		.q(cfg_s)
	);

	assign {mode_s, pwr_s, hrst_s, keep_s, duplex_s, ct1_s, kv1_s, ct2_s, kv2_s} = cfg_s;
	assign crst_n = resetn & hrst_s;
	// calibration enables follow the bank that the mode pin selects
	assign ct_en = mode_s ? ct2_s : ct1_s;
	assign kv_en = mode_s ? kv2_s : kv1_s;
	assign pwr_rise = pwr_s & ~pwr_d_q;

	// block power and path selection
	always_ff @(posedge clk)
	begin
		if (!crst_n)
		begin
			digital_on <= 1'b1;
			analog_on <= 1'b0;
			xo_bias_on <= 1'b0;
			bank2_active <= 1'b0;
			mixer1_on <= 1'b0;
			mixer2_on <= 1'b0;
		end
		else
		begin
			digital_on <= 1'b1;
			analog_on <= pwr_s;
			xo_bias_on <= pwr_s | keep_s;
			bank2_active <= mode_s;
			mixer1_on <= pwr_s & (duplex_s | ~mode_s);
			mixer2_on <= pwr_s & (duplex_s | mode_s);
		end
	end

	// enable edge detector
	always_ff @(posedge clk)
	begin
		if (!crst_n)
			pwr_d_q <= 1'b0;
		else
			pwr_d_q <= pwr_s;
	end

	// band selection: coarse tune then gain compensation; dropping enable aborts both
	always_ff @(posedge clk)
	begin
		if (!crst_n)
		begin
			cal_q <= TC_IDLE;
			tmr_q <= '0;
			ct_busy <= 1'b0;
			kv_busy <= 1'b0;
		end
		else
		begin
			unique case (cal_q)
				TC_IDLE:
				begin
					if (pwr_rise && ct_en)
					begin
						cal_q <= TC_CT;
						tmr_q <= TMR_W'(CT_CYC - 1);
						ct_busy <= 1'b1;
					end
					else if (pwr_rise && kv_en)
					begin
						cal_q <= TC_KV;
						tmr_q <= TMR_W'(KV_CYC - 1);
						kv_busy <= 1'b1;
					end
				end
				TC_CT:
				begin
					if (!pwr_s)
					begin
						cal_q <= TC_IDLE;
						ct_busy <= 1'b0;
					end
					else if (tmr_q == '0)
					begin
						ct_busy <= 1'b0;
						cal_q <= kv_en ? TC_KV : TC_IDLE;
						kv_busy <= kv_en;
						tmr_q <= TMR_W'(KV_CYC - 1);
					end
					else
						tmr_q <= tmr_q - TMR_W'(1);
				end
				TC_KV:
				begin
					if (!pwr_s || tmr_q == '0)
					begin
						cal_q <= TC_IDLE;
						kv_busy <= 1'b0;
					end
					else
						tmr_q <= tmr_q - TMR_W'(1);
				end
				default:
				begin
					cal_q <= TC_IDLE;
					ct_busy <= 1'b0;
					kv_busy <= 1'b0;
				end
			endcase
		end
	end
endmodule // tw_dev

// *** hdl/tw_host.sv ***
// Purpose: controller end; makes the serial clock and runs write, read and hard reset sequences
// Assumes: HALF_DIV of at least 3 so the two-flop input sync settles within half a serial period
// Notes: a hard reset sequence runs by itself after resetn, feeding the device reset edges
`timescale 1ns/1ns
module tw_host #(
	parameter int HALF_DIV = tw_pkg::HALF_DIV_DEF,
	parameter int SETTLE_CYC = tw_pkg::XO_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	tw_if.host bus,
	input wire logic req,
	input wire logic req_write,
	input wire logic [tw_pkg::ADDR_W-1:0] req_addr,
	input wire logic [tw_pkg::DATA_W-1:0] req_wdata,
	input wire logic hreset_req,
	input wire logic pwr_req,
	input wire logic mode_req,
	output logic busy,
	output logic done,
	output logic [tw_pkg::DATA_W-1:0] rd_data
);
	import tw_pkg::*;

	tw_host_state_type state_q;
	logic [7:0] div_q;
	logic sclk_q;
	logic [4:0] edge_q;
	logic [4:0] last_q;
	logic wr_q;
	logic sel_n_q;
	logic oe_q;
	logic out_q;
	logic [FRAME_W-1:0] sh_q;
	logic hrst_n_q;
	logic pwr_q;
	logic mode_q;
	logic [15:0] settle_q;
	logic io_s;
	logic run;
	logic tick;
	logic rise;
	logic fall;
	logic start;

	tw_sync #(.W(1)) u_io (
		.clk(clk),
		.d(bus.serial_io_line),
		.q(io_s)
	);

	assign bus.sclk = sclk_q;
	assign bus.serial_select_n = sel_n_q;
	assign bus.host_io_o = out_q;
	assign bus.host_io_oe = oe_q;
	assign bus.hard_reset_n = hrst_n_q;
	assign bus.chip_power_on = pwr_q;
	assign bus.mode = mode_q;

	assign run = state_q != TH_IDLE;
	assign tick = run && div_q == 8'(HALF_DIV - 1);
	assign rise = tick & ~sclk_q;
	assign fall = tick & sclk_q;
	assign start = state_q == TH_IDLE && req && !hreset_req;

	// serial clock divider; any HALF_DIV at or above HALF_DIV_MIN keeps below 19.2 MHz
	always_ff @(posedge clk)
	begin
		if (!resetn || !run || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// clock runs only inside a sequence and always stops low
	always_ff @(posedge clk)
	begin
		if (!resetn)
			sclk_q <= 1'b0;
		else if (tick)
			sclk_q <= ~sclk_q;
	end

	// rising edge count since the clock started
	always_ff @(posedge clk)
	begin
		if (!resetn || !run)
			edge_q <= 5'h00;
		else if (rise)
			edge_q <= edge_q + 5'h01;
	end

	// sequencer; a transfer ends on the falling edge after one trailing rising edge, a hard reset on the fall after edge E_RST_PERIODS
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_q <= TH_RST;
			wr_q <= 1'b1;
			last_q <= E_LAST_WR;
			done <= 1'b0;
			busy <= 1'b1;
		end
		else
		begin
			done <= 1'b0;
			unique case (state_q)
				TH_IDLE:
				begin
					busy <= hreset_req | req;
					if (hreset_req)
						state_q <= TH_RST;
					else if (req)
					begin
						state_q <= TH_RUN;
						wr_q <= req_write;
						last_q <= req_write ? E_LAST_WR : E_LAST_RD;
					end
				end
				TH_RUN:
				begin
					if (fall && edge_q == last_q + 5'h01)
					begin
						state_q <= TH_IDLE;
						done <= 1'b1;
						busy <= 1'b0;
					end
				end
				TH_RST:
				begin
					if (fall && edge_q == E_RST_PERIODS)
					begin
						state_q <= TH_IDLE;
						busy <= 1'b0;
					end
				end
				default:
					state_q <= TH_IDLE;
			endcase
		end
	end

	// select: the first rising edge passes with select high, so the device sees an extra edge
	always_ff @(posedge clk)
	begin
		if (!resetn)
			sel_n_q <= 1'b1;
		else if (fall && state_q == TH_RUN && edge_q == E_SEL_LOW)
			sel_n_q <= 1'b0;
		else if (fall && state_q == TH_RUN && edge_q == last_q)
			sel_n_q <= 1'b1;
	end

	// data line drive; bits change on falling edges so they are stable at the device's rising edge
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			oe_q <= 1'b0;
			out_q <= 1'b0;
			sh_q <= '0;
		end
		else if (start)
			sh_q <= {START_BIT, req_write ? OP_WRITE : OP_READ, req_addr, req_write ? req_wdata : {DATA_W{1'b0}}};
		else if (fall && state_q == TH_RUN)
		begin
			if (edge_q == (wr_q ? E_LAST_WR : E_HOST_REL_RD))
				oe_q <= 1'b0;
			else if (edge_q == E_SEL_LOW)
			begin
				oe_q <= 1'b1;
				out_q <= sh_q[FRAME_W-1];
			end
			else if (oe_q)
			begin
				out_q <= sh_q[FRAME_W-2];
				sh_q <= {sh_q[FRAME_W-2:0], 1'b0};
			end
		end
	end

	// read capture on falling edges
	always_ff @(posedge clk)
	begin
		if (!resetn)
			rd_data <= '0;
		else if (fall && state_q == TH_RUN && !wr_q && edge_q >= E_CAP_FIRST && edge_q <= E_CAP_LAST)
			rd_data <= {rd_data[DATA_W-2:0], io_s};
	end

	// hard reset low for the first rising edges of the sequence, far beyond 100 ns
	always_ff @(posedge clk)
	begin
		if (!resetn)
			hrst_n_q <= 1'b0;
		else
			hrst_n_q <= !(state_q == TH_RST && edge_q < E_RST_LOW);
	end

	// oscillator settle wait after reset before enable may rise
	always_ff @(posedge clk)
	begin
		if (!resetn || state_q == TH_RST)
			settle_q <= 16'h0000;
		else if (settle_q != 16'(SETTLE_CYC))
			settle_q <= settle_q + 16'h0001;
	end

	// enable and mode pins
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pwr_q <= 1'b0;
			mode_q <= 1'b0;
		end
		else
		begin
			pwr_q <= pwr_req && settle_q == 16'(SETTLE_CYC);
			mode_q <= mode_req;
		end
	end
endmodule // tw_host

// *** tb/tw_chk.sv ***
// Purpose: pin-level checker for the three-wire link
// Assumes: every pin is sampled on the 20 MHz clk
// Notes: serial clock edges are seen as data, so each counts as one sampled rise
`timescale 1ns/1ns
module tw_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic host_io_o,
	input wire logic host_io_oe,
	input wire logic dev_io_o,
	input wire logic dev_io_oe,
	input wire logic hard_reset_n
);
	logic sclk_q;
	logic hoe_q;
	logic rise;
	logic [2:0] ta_cnt_q;
	logic [4:0] sel_cnt_q;
	logic [4:0] drv_cnt_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// serial clock rise as seen from clk
	assign rise = sclk & ~sclk_q;

	// edge history
	always_ff @(posedge clk)
	begin
		sclk_q <= sclk;
		hoe_q <= host_io_oe;
	end

	// rises since the controller let go; saturates so it never wraps
	always_ff @(posedge clk)
	begin
		if (!resetn || (hoe_q && !host_io_oe))
			ta_cnt_q <= 3'h0;
		else if (rise && ta_cnt_q != 3'h7)
			ta_cnt_q <= ta_cnt_q + 3'h1;
	end

	// rises with select low, and rises while the device drives
	always_ff @(posedge clk)
	begin
		sel_cnt_q <= (!resetn || serial_select_n) ? 5'h00 : sel_cnt_q + {4'h0, rise};
		drv_cnt_q <= (!resetn || !dev_io_oe) ? 5'h00 : drv_cnt_q + {4'h0, rise};
	end

	sequence s_sclk_rise;
		$rose(sclk);
	endsequence
	sequence s_sclk_fall;
		$fell(sclk);
	endsequence

	// device state is unknown until a hard reset has run with clock edges
	property p_idle;
		disable iff (!resetn || !hard_reset_n) serial_select_n |-> !host_io_oe && !dev_io_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("data line driven while deselected");
	property p_no_clash;
		disable iff (!resetn || !hard_reset_n) !(host_io_oe && dev_io_oe);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive the data line");
	property p_sel_fall;
		$fell(serial_select_n) |-> s_sclk_fall;
	endproperty
	a_sel_fall: assert property (p_sel_fall) else $error("select fell off a falling clock");
	property p_host_shift;
		host_io_oe && $changed(host_io_o) |-> s_sclk_fall;
	endproperty
	a_host_shift: assert property (p_host_shift) else $error("controller data moved off a fall");
	property p_turn;
		$rose(dev_io_oe) |-> s_sclk_rise ##0 (ta_cnt_q == 3'h2);
	endproperty
	a_turn: assert property (p_turn) else $error("device drive not on third rise");
	property p_launch;
		disable iff (!resetn || !hard_reset_n) dev_io_oe && $changed(dev_io_o) |-> s_sclk_rise;
	endproperty
	a_launch: assert property (p_launch) else $error("read bit launched off a rise");
	property p_drive_len;
		disable iff (!resetn || !hard_reset_n) $fell(dev_io_oe) |-> drv_cnt_q == 5'h10;
	endproperty
	a_drive_len: assert property (p_drive_len) else $error("read data not sixteen bits");
	property p_frame;
		$rose(serial_select_n) |-> sel_cnt_q == 5'h19 || sel_cnt_q == 5'h1c;
	endproperty
	a_frame: assert property (p_frame) else $error("frame length wrong");
	property p_hreset;
		$fell(hard_reset_n) |-> !hard_reset_n [*2];
	endproperty
	a_hreset: assert property (p_hreset) else $error("hard reset pulse too short");
endmodule // tw_chk

// *** tb/tw_tb.sv ***
// Purpose: both ends joined, driven from the controller user port
// Assumes: HALF_DIV 4, settle count shortened to 20 clocks
// Notes: transfers leave notes; a monitor retires one per done pulse
`timescale 1ns/1ns
module tb;
	import tw_pkg::*;
	typedef struct packed {logic rd; logic [DATA_W-1:0] d;} tw_note_type;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic req = 1'b0;
	logic req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = 7'h00;
	logic [DATA_W-1:0] req_wdata = 16'h0000;
	logic hreset_req = 1'b0;
	logic pwr_req = 1'b0;
	logic mode_req = 1'b0;
	logic busy, done;
	logic [DATA_W-1:0] rd_data;
	logic digital_on, analog_on, xo_bias_on, bank2_active, mixer1_on, mixer2_on, ct_busy, kv_busy;
	int err_count = 0;
	int num_checks = 0;
	tw_note_type note_q[$];
	tw_note_type n;
	logic [ADDR_W-1:0] a_tab[3] = '{7'h7f, 7'h2a, 7'h00};
	logic [DATA_W-1:0] d_tab[3];

	always #25 clk = ~clk;

	tw_if u_tw_if();
	tw_host #(.HALF_DIV(4), .SETTLE_CYC(20)) u_tw_host (.clk(clk), .resetn(resetn), .bus(u_tw_if), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .hreset_req(hreset_req),
		.pwr_req(pwr_req), .mode_req(mode_req), .busy(busy), .done(done), .rd_data(rd_data));
	tw_dev u_tw_dev (.clk(clk), .resetn(resetn), .bus(u_tw_if), .digital_on(digital_on), .analog_on(analog_on),
		.xo_bias_on(xo_bias_on), .bank2_active(bank2_active), .mixer1_on(mixer1_on), .mixer2_on(mixer2_on),
		.ct_busy(ct_busy), .kv_busy(kv_busy));
	tw_chk u_tw_chk (.clk(clk), .resetn(resetn), .sclk(u_tw_if.sclk), .serial_select_n(u_tw_if.serial_select_n),
		.host_io_o(u_tw_if.host_io_o), .host_io_oe(u_tw_if.host_io_oe), .dev_io_o(u_tw_if.dev_io_o),
		.dev_io_oe(u_tw_if.dev_io_oe), .hard_reset_n(u_tw_if.hard_reset_n));

	task automatic chk_word(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] rd_data expected %h seen %h", exp, got);
		end
	endtask

	// order: digital, analog, xo, bank2, mixer1, mixer2, coarse tune, gain
	task automatic chk_pins(input logic [7:0] exp);
		logic [7:0] got;
		got = {digital_on, analog_on, xo_bias_on, bank2_active, mixer1_on, mixer2_on, ct_busy, kv_busy};
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] control pins expected %h seen %h", exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	// one transfer; a hang here is cut short by the watchdog
	task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		note_q.push_back({~w, d});
		req <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		while (busy !== 1'b1) @(posedge clk);
		req <= 1'b0;
		while (done !== 1'b1) @(posedge clk);
	endtask

	task automatic hard_reset();
		hreset_req <= 1'b1;
		@(posedge clk);
		while (busy !== 1'b1) @(posedge clk);
		hreset_req <= 1'b0;
		while (busy !== 1'b0) @(posedge clk);
	endtask

	// scoreboard: each done retires the oldest note, reads are compared
	always @(posedge clk)
	begin
		if (done === 1'b1 && note_q.size() > 0)
		begin
			n = note_q.pop_front();
			if (n.rd)
				chk_word(n.d, rd_data);
		end
	end

	// watchdog: whole sequence needs under ten thousand clocks
	initial
	begin
		cyc(20000);
		err_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		give_verdict();
	end

	initial
	begin
		void'($urandom(32'hc4eb0467));
		cyc(2);
		resetn <= 1'b1;
		@(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
		chk_pins(8'h80);
		op(1'b0, REG_CFG3, REG_RESET);
		// back-to-back writes, then read all back
		for (int k = 0; k < 3; k++)
		begin
			d_tab[k] = DATA_W'($urandom());
			op(1'b1, a_tab[k], d_tab[k]);
		end
		for (int k = 0; k < 3; k++)
			op(1'b0, a_tab[k], d_tab[k]);
		// keep-alive holds the oscillator with the enable pin low
		op(1'b1, REG_CFG3, 16'h0001);
		cyc(10);
		chk_pins(8'ha0);
		// every mode pin and duplex combination with the chip enabled
		for (int k = 0; k < 4; k++)
		begin
			op(1'b1, REG_CFG1, {14'h0000, k[1], 1'b0});
			mode_req <= k[0];
			pwr_req <= 1'b1;
			cyc(60);
			chk_pins({3'h7, k[0], k[1] | ~k[0], k[1] | k[0], 2'h0});
		end
		// enable rise runs coarse tune then gain compensation on bank 1
		pwr_req <= 1'b0;
		mode_req <= 1'b0;
		op(1'b1, REG_BANK1, 16'h1800);
		cyc(10);
		pwr_req <= 1'b1;
		cyc(60);
		chk_pins(8'hee);
		cyc(1100);
		chk_pins(8'hed);
		cyc(2000);
		chk_pins(8'hec);
		// mode high picks bank 2, whose gain compensation runs alone
		pwr_req <= 1'b0;
		mode_req <= 1'b1;
		op(1'b1, REG_BANK2, 16'h0800);
		cyc(10);
		pwr_req <= 1'b1;
		cyc(60);
		chk_pins(8'hfd);
		// enable low aborts calibration; keep-alive still holds the oscillator
		pwr_req <= 1'b0;
		cyc(10);
		chk_pins(8'hb0);
		// hard reset brings back defaults
		mode_req <= 1'b0;
		hard_reset();
		cyc(10);
		chk_pins(8'h80);
		op(1'b0, REG_CFG3, REG_RESET);
		op(1'b0, a_tab[0], REG_RESET);
		cyc(5);
		give_verdict();
	end
endmodule // tb
